// ---- src/pwm_clk_pkg.sv ----
// constants and carrier types for the pwm clocking and parallel channel control
// assumes one 20 MHz device clock; all limits are counted in device clock cycles
package pwm_clk_pkg;

  // channel configuration as seen by the pwm and diagnostic logic
  typedef struct packed {
    logic       clock_int;    // 1: internal clock, 0: external clock pin
    logic       prescaler;    // clock_prescaler_bit, 1 doubles the internal and external division
    logic       pwm_en;       // pwm module enable
    logic       on_bit;       // channel on-control bit
    logic [7:0] duty;         // duty code n, on time (n+1)/256
    logic [2:0] delay;        // switch-on delay code, 32 pwm clock periods per step
    logic       sense_ratio;  // current-sense ratio bit
    logic       ol_on_en;     // on-state open-load reporting enable
    logic       ol_off_en;    // off-state open-load reporting enable
    logic       os_en;        // short-to-supply reporting enable
  } chan_cfg_t;

  // one channel's fault bits, latchable ones in the low three bits
  typedef struct packed {
    logic os;
    logic open_load_off_flag;
    logic open_load_on_flag;
    logic ot;
    logic sc;
    logic oc;
  } fault_t;

  localparam int         FAULT_W       = 6;
  localparam logic [5:0] LATCH_MASK    = 6'h07;
  localparam logic [7:0] DUTY_FULL     = 8'hff;
  localparam logic [4:0] DELAY_LSBS    = 5'h00;  // code times 32
  localparam int         CAL_CNT_W     = 24;
  localparam int         CAL_SHIFT     = 8;      // switching period is 256 internal periods
  localparam int         PERIOD_W      = 16;
  localparam int         GAP_W         = 16;

  // reset values and default limits
  localparam logic [15:0] INT_PERIOD_RST = 16'h00c8;
  localparam logic [23:0] CAL_MIN_DEF    = 24'h008c00;
  localparam logic [23:0] CAL_MAX_DEF    = 24'h010400;
  localparam logic [15:0] EXT_MIN_GAP_DEF = 16'h0004;
  localparam logic [15:0] EXT_MAX_GAP_DEF = 16'h1000;

endpackage

// ---- src/pwm_clocking_parallel_ctrl.sv ----
// pwm clocking, clock monitor, internal clock calibration and parallel mode for two channels
// assumes the serial port logic delivers register contents and one-cycle read/write strobes
// on clk; the external pwm clock and chip select arrive as raw pins
module pwm_clocking_parallel_ctrl #(
  parameter logic [15:0] INT_PERIOD_DEFAULT = pwm_clk_pkg::INT_PERIOD_RST,
  parameter logic [23:0] CAL_MIN_CYCLES     = pwm_clk_pkg::CAL_MIN_DEF,
  parameter logic [23:0] CAL_MAX_CYCLES     = pwm_clk_pkg::CAL_MAX_DEF,
  parameter logic [15:0] EXT_MIN_GAP        = pwm_clk_pkg::EXT_MIN_GAP_DEF,
  parameter logic [15:0] EXT_MAX_GAP        = pwm_clk_pkg::EXT_MAX_GAP_DEF
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   nrst,
  // pins
  input  wire logic                   ext_pwm_clk,
  input  wire logic                   chip_select_n,
  // register contents
  input  wire pwm_clk_pkg::chan_cfg_t cfg_ch0,
  input  wire pwm_clk_pkg::chan_cfg_t cfg_ch1,
  input  wire logic                   parallel,
  input  wire logic [3:0]             retry_count_ch0,
  input  wire logic [3:0]             retry_count_ch1,
  // strobes from the serial port
  input  wire logic                   cal_word_wr,
  input  wire logic                   diag_read,
  input  wire logic [1:0]             fault_read,
  input  wire logic [1:0]             delatch_req,
  // raw detector outputs
  input  wire pwm_clk_pkg::fault_t    det_ch0,
  input  wire pwm_clk_pkg::fault_t    det_ch1,
  // outputs
  output logic [1:0]                  hs_on,
  output logic                        fault_out_n,
  output logic                        clock_fail,
  output pwm_clk_pkg::fault_t         flags_ch0,
  output pwm_clk_pkg::fault_t         flags_ch1,
  output pwm_clk_pkg::chan_cfg_t      eff_cfg_ch1,
  output logic [3:0]                  retry_readback_ch1,
  output logic [15:0]                 int_period
);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detection

  logic ck_meta_ff, ck_sync_ff, ck_dly_ff;
  logic cs_meta_ff, cs_sync_ff, cs_dly_ff;

  // two flops before use, third flop only for edges
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ck_meta_ff <= 1'b0;
      ck_sync_ff <= 1'b0;
      ck_dly_ff  <= 1'b0;
      cs_meta_ff <= 1'b1;
      cs_sync_ff <= 1'b1;
      cs_dly_ff  <= 1'b1;
    end else begin
      ck_meta_ff <= ext_pwm_clk;
      ck_sync_ff <= ck_meta_ff;
      ck_dly_ff  <= ck_sync_ff;
      cs_meta_ff <= chip_select_n;
      cs_sync_ff <= cs_meta_ff;
      cs_dly_ff  <= cs_sync_ff;
    end
  end

  wire ext_edge = ck_sync_ff & ~ck_dly_ff;
  wire cs_fall  = cs_dly_ff & ~cs_sync_ff;
  wire cs_rise  = ~cs_dly_ff & cs_sync_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // effective channel configuration

  pwm_clk_pkg::chan_cfg_t cfg_eff [2];
  pwm_clk_pkg::chan_cfg_t mirror_cfg;

  // bank 0 replaces bank 1, channel 1 keeps its own diagnostic enables
  always_comb begin
    mirror_cfg           = cfg_ch0;
    mirror_cfg.ol_on_en  = cfg_ch1.ol_on_en;
    mirror_cfg.ol_off_en = cfg_ch1.ol_off_en;
    mirror_cfg.os_en     = cfg_ch1.os_en;
  end

  assign cfg_eff[0] = cfg_ch0;
  assign cfg_eff[1] = parallel ? mirror_cfg : cfg_ch1;

  wire [7:0] ch0_duty  = cfg_ch0.duty;
  wire       ch0_sense = cfg_ch0.sense_ratio;

  ////////////////////////////////////////////////////////////////////////////////
  // internal clock and calibration

  logic [15:0] int_period_ff;
  logic [15:0] int_cnt_ff;
  logic        cal_arm_ff;
  logic        cal_meas_ff;
  logic [23:0] cal_cnt_ff;

  wire        int_tick   = (int_cnt_ff == 16'h0000);
  wire [15:0] int_reload = 16'(int_period_ff - 16'h0001);
  wire        cal_in_win = (cal_cnt_ff >= CAL_MIN_CYCLES) && (cal_cnt_ff <= CAL_MAX_CYCLES);
  wire [15:0] cal_raw    = cal_cnt_ff[pwm_clk_pkg::CAL_SHIFT +: pwm_clk_pkg::PERIOD_W];
  wire [15:0] cal_period = (cal_raw == 16'h0000) ? 16'h0001 : cal_raw;
  wire        cal_done   = cal_meas_ff & cs_rise;

  // internal clock divider, one tick per internal clock period
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      int_cnt_ff <= 16'h0000;
    end else if (int_tick) begin
      int_cnt_ff <= int_reload;
    end else begin
      int_cnt_ff <= 16'(int_cnt_ff - 16'h0001);
    end
  end

  // arm on the calibration word, time the next low pulse of chip select
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cal_arm_ff    <= 1'b0;
      cal_meas_ff   <= 1'b0;
      cal_cnt_ff    <= 24'h000000;
      int_period_ff <= INT_PERIOD_DEFAULT;
    end else begin
      if (cal_arm_ff && cs_fall) begin
        cal_arm_ff  <= 1'b0;
        cal_meas_ff <= 1'b1;
        cal_cnt_ff  <= 24'h000000;
      end else if (cal_word_wr) begin
        cal_arm_ff  <= 1'b1;
      end
      if (cal_meas_ff && !cal_done && (cal_cnt_ff != 24'hffffff)) begin
        cal_cnt_ff  <= 24'(cal_cnt_ff + 24'h000001);     // saturates, reads as too long
      end
      if (cal_done) begin
        cal_meas_ff <= 1'b0;
        if (cal_in_win) begin
          int_period_ff <= cal_period;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // external clock monitor

  logic [15:0] gap_ff;
  logic        clock_fail_ff;
  logic        read_seen_ff;
  logic        mon_edge_ff;

  // watch only while some channel really runs on the external clock
  wire mon_act  = (~cfg_eff[0].clock_int & cfg_eff[0].pwm_en) |
                  (~cfg_eff[1].clock_int & cfg_eff[1].pwm_en);
  // the first edge after monitor start only opens a gap, it measures nothing
  wire too_fast = ext_edge & mon_edge_ff & (gap_ff < EXT_MIN_GAP);
  wire too_slow = (gap_ff > EXT_MAX_GAP);
  wire bad_clk  = mon_act & (too_fast | too_slow);
  wire good_clk = ext_edge & ~too_fast & ~too_slow;
  wire fail_clr = read_seen_ff & (good_clk | ~mon_act);

  // gap counter saturates one above the limit so a stopped clock stays bad
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gap_ff      <= 16'h0000;
      mon_edge_ff <= 1'b0;
    end else if (!mon_act) begin
      gap_ff      <= 16'h0000;
      mon_edge_ff <= 1'b0;
    end else if (ext_edge) begin
      gap_ff      <= 16'h0000;
      mon_edge_ff <= 1'b1;
    end else if (!too_slow) begin
      gap_ff <= 16'(gap_ff + 16'h0001);
    end
  end

  // a new failure wins over a pending recovery
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      clock_fail_ff <= 1'b0;
      read_seen_ff  <= 1'b0;
    end else begin
      if (bad_clk) begin
        clock_fail_ff <= 1'b1;
      end else if (fail_clr) begin
        clock_fail_ff <= 1'b0;
      end
      read_seen_ff <= clock_fail_ff & ~bad_clk & ~fail_clr & (read_seen_ff | diag_read);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // protection combining

  pwm_clk_pkg::fault_t det_arr [2];
  assign det_arr[0] = det_ch0;
  assign det_arr[1] = det_ch1;

  wire [2:0] lat_comb = det_ch0[2:0] | det_ch1[2:0];
  wire [1:0] lat_w;
  wire [1:0] on_w;
  wire [5:0] flg_w [2];

  ////////////////////////////////////////////////////////////////////////////////
  // per channel pwm, latch and fault flags

  for (genvar i = 0; i < 2; i++) begin : g_ch
    logic       en_d_ff;
    logic       pre_ff;
    logic       lat_ff;
    logic       on_ff;
    logic [7:0] dly_ff;
    logic [7:0] ph_ff;
    logic [5:0] flg_ff;
    logic       nxt_on;
    pwm_clk_pkg::fault_t set_s;

    wire       ext_mode = ~cfg_eff[i].clock_int;
    wire       src_tick = ext_mode ? (ext_edge & ~clock_fail_ff) : int_tick;
    wire       tick     = src_tick & (~cfg_eff[i].prescaler | pre_ff);
    wire       en_rise  = cfg_eff[i].pwm_en & ~en_d_ff;
    wire       running  = (dly_ff == 8'h00);
    wire [2:0] dly_code = cfg_eff[i].delay;
    wire       pwm_lvl  = (cfg_eff[i].duty == pwm_clk_pkg::DUTY_FULL) |
                          (ph_ff <= cfg_eff[i].duty);
    wire [2:0] prot     = parallel ? lat_comb : det_arr[i][2:0];
    wire       delatch  = parallel ? delatch_req[0] : delatch_req[i];
    wire [5:0] set_v    = set_s;
    wire [5:0] keep_v   = set_v | (lat_ff ? pwm_clk_pkg::LATCH_MASK : 6'h00);
    wire [5:0] clr_v    = fault_read[i] ? ~keep_v : 6'h00;

    // new fault bits, open-load and supply short under the channel's own enables
    always_comb begin
      set_s       = '0;
      set_s.oc    = prot[0];
      set_s.sc    = prot[1];
      set_s.ot    = prot[2];
      set_s.open_load_on_flag  = det_arr[i].open_load_on_flag & cfg_eff[i].ol_on_en;
      set_s.open_load_off_flag = det_arr[i].open_load_off_flag & cfg_eff[i].ol_off_en;
      set_s.os    = det_arr[i].os & cfg_eff[i].os_en;
    end

    // output priority: latch, on bit, static on, clock failure, pwm
    always_comb begin
      if (lat_ff || (|prot)) begin
        nxt_on = 1'b0;
      end else if (!cfg_eff[i].on_bit) begin
        nxt_on = 1'b0;
      end else if (!cfg_eff[i].pwm_en) begin
        nxt_on = 1'b1;
      end else if (ext_mode && clock_fail_ff) begin
        nxt_on = 1'b1;
      end else begin
        nxt_on = running & pwm_lvl & ~en_rise;            // no stale phase on restart
      end
    end

    // enable edge restarts phase, prescaler and delay, so equal setups stay in lockstep
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        en_d_ff <= 1'b0;
        pre_ff  <= 1'b0;
        dly_ff  <= 8'h00;
        ph_ff   <= 8'h00;
      end else begin
        en_d_ff <= cfg_eff[i].pwm_en;
        if (en_rise) begin
          pre_ff <= 1'b0;
          dly_ff <= {dly_code, pwm_clk_pkg::DELAY_LSBS};
          ph_ff  <= 8'h00;
        end else begin
          if (src_tick) begin
            pre_ff <= cfg_eff[i].prescaler & ~pre_ff;
          end
          if (tick && !running) begin
            dly_ff <= 8'(dly_ff - 8'h01);
          end else if (tick) begin
            ph_ff  <= 8'(ph_ff + 8'h01);
          end
        end
      end
    end

    // latch and flags: a fault in the clear cycle wins
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        lat_ff <= 1'b0;
        on_ff  <= 1'b0;
        flg_ff <= 6'h00;
      end else begin
        lat_ff <= (lat_ff & ~delatch) | (|prot);
        on_ff  <= nxt_on;
        flg_ff <= (flg_ff & ~clr_v) | set_v;
      end
    end

    assign lat_w[i] = lat_ff;
    assign on_w[i]  = on_ff;
    assign flg_w[i] = flg_ff;

    AST_OFF_BIT0: assert property (!cfg_eff[i].on_bit |=> !hs_on[i])
      else $error("channel on while its on bit is clear");
    AST_FAIL_FOLLOW: assert property ((ext_mode && cfg_eff[i].pwm_en && clock_fail_ff &&
      !lat_ff && !delatch && !(|prot)) |=> hs_on[i] == $past(cfg_eff[i].on_bit))
      else $error("channel does not follow on bit during clock failure");
    AST_DELAY_LOAD: assert property (en_rise |=> dly_ff == {$past(dly_code), 5'h00})
      else $error("switch-on delay not loaded as code times 32");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // readback mirror, fault pin and output registers

  logic [3:0]             retry_ff;
  logic [3:0]             retry_prev_ff;
  logic                   fault_n_ff;
  pwm_clk_pkg::chan_cfg_t eff_cfg_ff;

  wire retry_new = (retry_count_ch0 != retry_prev_ff);
  wire nxt_fault = clock_fail_ff | (|lat_w) | (|lat_comb);

  // channel 1 readback copied from channel 0 only when channel 0 changes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      retry_ff      <= 4'h0;
      retry_prev_ff <= 4'h0;
      fault_n_ff    <= 1'b1;
      eff_cfg_ff    <= '0;
    end else begin
      retry_prev_ff <= retry_count_ch0;
      if (!parallel) begin
        retry_ff <= retry_count_ch1;
      end else if (retry_new) begin
        retry_ff <= retry_count_ch0;
      end
      fault_n_ff <= ~nxt_fault;
      eff_cfg_ff <= cfg_eff[1];
    end
  end

  assign hs_on              = on_w;
  assign fault_out_n        = fault_n_ff;
  assign clock_fail         = clock_fail_ff;
  assign flags_ch0          = flg_w[0];
  assign flags_ch1          = flg_w[1];
  assign eff_cfg_ch1        = eff_cfg_ff;
  assign retry_readback_ch1 = retry_ff;
  assign int_period         = int_period_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_cal_end_bad;
    cal_meas_ff && cs_rise && !cal_in_win;
  endsequence

  sequence s_cal_end_good;
    cal_meas_ff && cs_rise && cal_in_win;
  endsequence

  AST_CAL_REJECT: assert property (s_cal_end_bad |=> $stable(int_period_ff))
    else $error("out-of-window pulse changed the internal period");
  AST_CAL_SET: assert property (s_cal_end_good |=> int_period_ff == $past(cal_period))
    else $error("internal period not set from measured low time");
  AST_MON_IDLE: assert property (!mon_act |=> !$rose(clock_fail_ff))
    else $error("clock failure raised while not monitoring");
  AST_FAIL_PIN: assert property ($rose(clock_fail_ff) |=> !fault_out_n)
    else $error("fault pin not low after clock failure");
  AST_PAR_OC: assert property (parallel && (det_ch0.oc || det_ch1.oc)
    |=> flags_ch0.oc && flags_ch1.oc && hs_on == 2'b00)
    else $error("parallel overcurrent not applied to both channels");
  AST_PAR_SC: assert property (parallel && (det_ch0.sc || det_ch1.sc)
    |=> flags_ch0.sc && flags_ch1.sc && hs_on == 2'b00)
    else $error("parallel severe short not applied to both channels");
  AST_PAR_OT: assert property (parallel && (det_ch0.ot || det_ch1.ot)
    |=> flags_ch0.ot && flags_ch1.ot && hs_on == 2'b00)
    else $error("parallel overtemperature not applied to both channels");
  AST_PAR_CFG: assert property (parallel |=> eff_cfg_ch1.duty == $past(ch0_duty) &&
    eff_cfg_ch1.sense_ratio == $past(ch0_sense))
    else $error("channel 1 configuration not mirrored from channel 0");
  AST_RETRY_MIRROR: assert property (parallel && retry_new
    |=> retry_readback_ch1 == $past(retry_count_ch0))
    else $error("retry readback not copied from channel 0");

endmodule

// ---- tb/pwm_clocking_parallel_ctrl_tb.sv ----
// self-checking bench for the pwm clocking and parallel channel control
// assumes the small parameter set below; expectations come from the bench model
module pwm_clocking_parallel_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                   clk, nrst, run, ext_pwm_clk, chip_select_n, parallel;
  logic                   cal_word_wr, diag_read, fault_out_n, clock_fail;
  logic [3:0]             retry_count_ch0, retry_count_ch1, retry_readback_ch1;
  logic [1:0]             fault_read, delatch_req, hs_on;
  logic [15:0]            int_period;
  pwm_clk_pkg::chan_cfg_t cfg_ch0, cfg_ch1, eff_cfg_ch1, c;
  pwm_clk_pkg::fault_t    det_ch0, det_ch1, flags_ch0, flags_ch1;
  int                     failures = 0, n_checks = 0, cyc = 0, seed = 32'hf85ae519;
  int                     lat0, lat7, hi, per;
  logic [7:0]             n;
  logic [7:0]             rr;
  logic [3:0]             rb;

  ////////////////////////////////////////////////////////////////////////////////
  pwm_clocking_parallel_ctrl #(.INT_PERIOD_DEFAULT(16'h0004), .CAL_MIN_CYCLES(24'h000100),
    .CAL_MAX_CYCLES(24'h000400), .EXT_MIN_GAP(16'h0004), .EXT_MAX_GAP(16'h0040)) dut_u (
    .clk(clk), .nrst(nrst), .ext_pwm_clk(ext_pwm_clk), .chip_select_n(chip_select_n),
    .cfg_ch0(cfg_ch0), .cfg_ch1(cfg_ch1), .parallel(parallel),
    .retry_count_ch0(retry_count_ch0), .retry_count_ch1(retry_count_ch1),
    .cal_word_wr(cal_word_wr), .diag_read(diag_read), .fault_read(fault_read),
    .delatch_req(delatch_req), .det_ch0(det_ch0), .det_ch1(det_ch1), .hs_on(hs_on),
    .fault_out_n(fault_out_n), .clock_fail(clock_fail), .flags_ch0(flags_ch0),
    .flags_ch1(flags_ch1), .eff_cfg_ch1(eff_cfg_ch1), .retry_readback_ch1(retry_readback_ch1),
    .int_period(int_period));
  pwm_host_model host_u (.clk(clk), .run(run), .ext_pwm_clk(ext_pwm_clk),
    .chip_select_n(chip_select_n));

  ////////////////////////////////////////////////////////////////////////////////
  // 50 ns clock; hang guard sized well above the planned run
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      failures++;
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [18:0] exp, input logic [18:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk_int(input string nm, input int exp, input int got);
    n_checks++;
    if (got != exp) begin
      failures++;
      $display("[FAIL] %s expected %0d seen %0d", nm, exp, got);
    end
  endtask
  task automatic wt(input int k);
    repeat (k) @(posedge clk);
  endtask
  // one-cycle strobes: cal word, diag read, fault reads, delatches
  task automatic strobe(input logic [5:0] s);
    @(posedge clk);
    {cal_word_wr, diag_read, fault_read, delatch_req} <= s;
    @(posedge clk);
    {cal_word_wr, diag_read, fault_read, delatch_req} <= 6'h00;
  endtask
  task automatic wait_cf(input logic v);
    for (int i = 0; i < 200 && clock_fail !== v; i++) @(posedge clk);
  endtask
  // both channels identical, enable aligned to an ext edge; returns latency and high cycles
  task automatic run_pwm(input logic p, input logic [2:0] d, input logic [7:0] dn,
                         output int lat, output int high);
    int mism;
    c = pwm_clk_pkg::chan_cfg_t'(19'h0);
    {c.prescaler, c.delay, c.duty} = {p, d, dn};
    @(posedge clk);
    {cfg_ch0, cfg_ch1} <= {c, c};
    wt(4);
    @(posedge ext_pwm_clk);
    wt(2); // enable lands on the synchronised edge, so phase 0 is a full period
    {c.pwm_en, c.on_bit} = 2'b11;
    {cfg_ch0, cfg_ch1} <= {c, c};
    lat = 0;
    while (hs_on[0] !== 1'b1 && lat < 9000) begin
      @(posedge clk);
      lat++;
    end
    high = 0;
    mism = 0;
    repeat (2560 * (int'(p) + 1)) begin
      @(posedge clk);
      high += int'(hs_on[0] === 1'b1);
      mism += int'(hs_on[0] !== hs_on[1]);
    end
    chk_int("unsynchronised cycles", 0, mism);
  endtask
  task automatic test_done();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {nrst, run, parallel, cal_word_wr, diag_read, fault_read, delatch_req} = '0;
    {cfg_ch0, cfg_ch1, det_ch0, det_ch1, retry_count_ch0, retry_count_ch1} = '0;
    wt(12);
    chk("reset outputs", 19'h14, {hs_on, fault_out_n, clock_fail, int_period[2:0]});
    nrst <= 1'b1;
    // mirror of bank 0 except channel 1 diagnostic enables, retry mirror
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      c = pwm_clk_pkg::chan_cfg_t'(19'($random(seed)));
      c.pwm_en = 1'b0; // keeps channel 0, and channel 1 in parallel, off the clock monitor
      cfg_ch0 <= c;
      cfg_ch1 <= pwm_clk_pkg::chan_cfg_t'(19'($random(seed)) & 19'h5dfff);
      parallel <= i[0];
      rr = 8'($random(seed));
      // channel 1 readback follows channel 1, in parallel moves only when channel 0 brings a new value
      if (!i[0]) rb = rr[3:0];
      else if (rr[7:4] != retry_count_ch0) rb = rr[7:4];
      {retry_count_ch0, retry_count_ch1} <= rr;
      wt(3);
      chk("eff_cfg_ch1", parallel ? {cfg_ch0[18:3], cfg_ch1[2:0]} : cfg_ch1, eff_cfg_ch1);
      chk("retry_readback_ch1", 19'(rb), 19'(retry_readback_ch1));
    end
    $display("test mirror done");
    // combined latchable faults in parallel, delatch through channel 0
    c = pwm_clk_pkg::chan_cfg_t'(19'h0);
    {c.clock_int, c.on_bit, c.os_en} = 3'b111;
    cfg_ch0 <= c;
    c.os_en = 1'b0;
    cfg_ch1 <= c;
    parallel <= 1'b1;
    wt(4);
    for (int i = 0; i < 3; i++) begin
      chk("hs_on full", 19'h3, 19'(hs_on));
      @(posedge clk);
      if (i == 1) det_ch0 <= pwm_clk_pkg::fault_t'(6'(1 << i));
      else det_ch1 <= pwm_clk_pkg::fault_t'(6'(1 << i));
      @(posedge clk);
      {det_ch0, det_ch1} <= '0;
      strobe(6'h0c);
      wt(2);
      chk("flags both", 19'({6'(1 << i), 6'(1 << i)}), 19'({flags_ch0, flags_ch1}));
      chk("latched off", 19'h0, 19'({hs_on, fault_out_n}));
      strobe(6'h01);
      strobe(6'h0c);
      wt(3);
      chk("delatched", 19'h7, 19'({flags_ch0, flags_ch1, hs_on, fault_out_n}));
    end
    det_ch0 <= pwm_clk_pkg::fault_t'(6'h20);
    det_ch1 <= pwm_clk_pkg::fault_t'(6'h20);
    wt(4);
    chk("short to supply", 19'h800, 19'({flags_ch0, flags_ch1}));
    {det_ch0, det_ch1} <= '0;
    strobe(6'h0c);
    parallel <= 1'b0;
    $display("test faults done");
    // calibration: in window, too long, too short, not armed
    per = 4;
    for (int i = 0; i < 4; i++) begin
      int len[4] = '{800, 1100, 200, 600};
      if (i != 3) strobe(6'h20);
      host_u.cs_low(len[i]);
      wt(6);
      if (i == 0) per = len[i] >> 8;
      chk("int_period", 19'(per), 19'(int_period));
    end
    $display("test calibration done");
    // external pwm: duty, prescaler, start delay
    run <= 1'b1;
    n = 8'($random(seed));
    run_pwm(1'b0, 3'd0, n, lat0, hi);
    chk_int("high cycles div256", (int'(n) + 1) * 10, hi);
    run_pwm(1'b0, 3'd7, pwm_clk_pkg::DUTY_FULL, lat7, hi);
    chk_int("high cycles full", 2560, hi);
    chk_int("start delay", 7 * 32 * 10, lat7 - lat0);
    n = 8'($random(seed));
    run_pwm(1'b1, 3'd0, n, lat0, hi);
    chk_int("high cycles div512", (int'(n) + 1) * 20, hi);
    $display("test pwm done");
    // clock monitor: idle unless enabled, failure, fallback, recovery after read
    run <= 1'b0;
    c = pwm_clk_pkg::chan_cfg_t'(19'h0);
    c.on_bit = 1'b1;
    {cfg_ch0, cfg_ch1} <= {c, pwm_clk_pkg::chan_cfg_t'(19'h0)};
    wt(150);
    chk("idle monitor", 19'h0, 19'(clock_fail));
    c.pwm_en = 1'b1;
    cfg_ch0 <= c;
    wait_cf(1'b1);
    wt(3);
    chk("clock failure", 19'h5, 19'({clock_fail, fault_out_n, hs_on[0]}));
    c.on_bit = 1'b0;
    cfg_ch0 <= c;
    wt(3);
    chk("fallback off", 19'h0, 19'(hs_on[0]));
    run <= 1'b1;
    wt(100);
    chk("held without read", 19'h1, 19'(clock_fail));
    strobe(6'h10);
    wait_cf(1'b0);
    wt(3);
    chk("recovered", 19'h1, 19'({clock_fail, fault_out_n}));
    $display("test monitor done");
    test_done();
  end
endmodule

// ---- tb/pwm_host_model.sv ----
// far-side model: the host that supplies the pwm clock pin and pulses chip select
// assumes the bench clock; all pin changes happen just after a rising clk edge
module pwm_host_model #(
  parameter int HALF = 5
) (
  input  wire logic clk,
  input  wire logic run,
  output logic      ext_pwm_clk,
  output logic      chip_select_n
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;

  initial begin
    ext_pwm_clk = 1'b0;
    chip_select_n = 1'b1;
  end

  // clock runs only while run is high, stands still low otherwise
  always @(posedge clk) begin
    if (!run) begin
      cnt <= 0;
      ext_pwm_clk <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      ext_pwm_clk <= ~ext_pwm_clk;
    end else begin
      cnt <= cnt + 1;
    end
  end

  // timing pulse after the calibration word, low for n clk cycles
  task automatic cs_low(input int n);
    @(posedge clk);
    chip_select_n <= 1'b0;
    repeat (n) @(posedge clk);
    chip_select_n <= 1'b1;
  endtask
endmodule
